/* File: verilog/usb_host_td_status_writeback.sv */
// Descriptor completion status, retirement and shared-area write-back
//
// Behaviour
// - General descriptor code written only at retirement
// - Iso packet code per packet, overall at retire
// - Code 0000 means no error
// - CRC 0001, stuffing 0010, no response 0101
// - Toggle 0011, PID check 0110, bad PID 0111
// - STALL retires with code 0100
// - Overrun 1000, underrun 1001
// - Iso memory late: write 1100, read 1101
// - Preloaded 111x means not yet processed
// - Error writes code and halts the endpoint
// - Transmission errors retried, retire on third
// - STALL, overrun, underrun retire at once
// - Late iso packet skipped, status left untouched
// - Iso retire: ok or overrun, never halt
// - Read one of 32 periodic heads per frame
// - Write frame number at 0x80, zero at 0x82
// - Count, SOF, frame write, then endpoint fetch
// - Write head at 0x84 once until cleared
// - Head LSB set when other causes pending
// - Write head after the descriptor delay expires
// - One packet per endpoint, then move on
// - Iso in size recorded, zero for out
// - Retire links descriptor onto retired queue
`timescale 1ns/1ps
module usb_host_td_status_writeback (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Frame timing and start-of-frame sender
  input  wire logic        frameTick,
  output logic             sofReq,
  input  wire logic        sofDone,
  output logic      [15:0] internalFrameCount,
  output logic      [31:0] periodicHead,
  output logic             edFetchStart,
  // Shared area and write-back control
  input  wire logic [23:0] areaBase,
  input  wire logic        writebackEnable,
  input  wire logic        writebackClear,
  input  wire logic        otherIrqPending,
  output logic             writebackStatus,
  output logic      [31:0] retiredQueueHead,
  // Packet outcome
  input  wire logic        resultValid,
  output logic             resultReady,
  input  wire logic        crcErr,
  input  wire logic        stuffErr,
  input  wire logic        noResp,
  input  wire logic        toggleErr,
  input  wire logic        stallPid,
  input  wire logic        pidCheckErr,
  input  wire logic        badPid,
  input  wire logic        overrun,
  input  wire logic        underrun,
  input  wire logic        memWriteLate,
  input  wire logic        memReadLate,
  // Descriptor context of the outcome
  input  wire logic        isoMode,
  input  wire logic        isoIn,
  input  wire logic        isoSkipped,
  input  wire logic [2:0]  pktIndex,
  input  wire logic [10:0] rxSize,
  input  wire logic        tdLastPacket,
  input  wire logic [1:0]  tdErrCount,
  input  wire logic [2:0]  tdIrqDelay,
  input  wire logic [31:0] tdAddr,
  input  wire logic [31:0] tdNextPtr,
  input  wire logic [27:0] tdWord0Rest,
  input  wire logic [31:0] edAddr,
  input  wire logic        edToggleCarry,
  // Outcome verdict
  output logic             edAdvance,
  output logic             tdRetry,
  output logic      [1:0] tdNewErrCount,
  output logic             edHalted,
  output logic             tdRetired,
  // System memory port
  output logic             memReq,
  output logic             memWrite,
  output logic      [31:0] memAddr,
  output logic      [31:0] memWdata,
  output logic      [3:0]  memBe,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata
);
  import td_status_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t      state, next_state;
  logic        framePending, next_framePending;
  logic [2:0]  delayCnt, next_delayCnt;
  logic        headPending, next_headPending;
  logic        next_writebackStatus;
  logic [31:0] next_retiredQueueHead;
  logic [15:0] next_internalFrameCount;
  logic [31:0] next_periodicHead;
  logic        next_sofReq, next_edFetchStart;
  logic        next_edAdvance, next_tdRetry, next_edHalted, next_tdRetired;
  logic [1:0]  next_tdNewErrCount;
  logic        next_memReq, next_memWrite;
  logic [31:0] next_memAddr, next_memWdata;
  logic [3:0]  next_memBe;
  // Captured outcome
  logic [3:0]  capCode, next_capCode;
  logic        capHalt, next_capHalt;
  logic [2:0]  capDelay, next_capDelay;
  logic [31:0] capTd, next_capTd;
  logic [31:0] capNext, next_capNext;
  logic [27:0] capRest, next_capRest;
  logic [31:0] capEd, next_capEd;
  logic        capCarry, next_capCarry;
  logic        capLast, next_capLast;

  // ---------------------------------------------------------------
  // Outcome classification
  // ---------------------------------------------------------------
  logic [3:0]  clsCode;
  logic        clsRetire, clsRetry, clsHalt;
  logic [1:0]  clsErrCount;
  logic [15:0] pswWord;
  logic [31:0] pswAddr;
  logic [2:0]  decDelay;
  logic        wbDue;

  cc_classifier u_classifier (
    .crcErr       (crcErr),
    .stuffErr     (stuffErr),
    .noResp       (noResp),
    .toggleErr    (toggleErr),
    .stallPid     (stallPid),
    .pidCheckErr  (pidCheckErr),
    .badPid       (badPid),
    .overrun      (overrun),
    .underrun     (underrun),
    .memWriteLate (memWriteLate),
    .memReadLate  (memReadLate),
    .isoMode      (isoMode),
    .tdLastPacket (tdLastPacket),
    .errCount     (tdErrCount),
    .code         (clsCode),
    .retire       (clsRetire),
    .retry        (clsRetry),
    .halt         (clsHalt),
    .nextErrCount (clsErrCount)
  );

  assign pswWord = {clsCode, 1'b0, (isoIn ? rxSize : 11'h000)};
  assign pswAddr = tdAddr + ISO_PSW_OFS + {28'h000_0000, pktIndex, 1'b0};
  assign resultReady = (state == ST_IDLE) && !framePending && !frameTick;
  assign decDelay = (frameTick && headPending && delayCnt != 3'h0) ? delayCnt - 3'h1 : delayCnt;
  assign wbDue = headPending && (delayCnt == 3'h0) && writebackEnable && !writebackStatus;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state              = state;
    next_framePending       = framePending | frameTick;
    next_delayCnt           = decDelay;
    next_headPending        = headPending;
    next_writebackStatus    = writebackStatus & ~writebackClear;
    next_retiredQueueHead   = retiredQueueHead;
    next_internalFrameCount = internalFrameCount;
    next_periodicHead       = periodicHead;
    next_sofReq             = sofReq;
    next_edFetchStart       = 1'b0;
    next_edAdvance          = 1'b0;
    next_tdRetry            = 1'b0;
    next_edHalted           = 1'b0;
    next_tdRetired          = 1'b0;
    next_tdNewErrCount      = tdNewErrCount;
    next_memReq             = memReq;
    next_memWrite           = memWrite;
    next_memAddr            = memAddr;
    next_memWdata           = memWdata;
    next_memBe              = memBe;
    next_capCode            = capCode;
    next_capHalt            = capHalt;
    next_capDelay           = capDelay;
    next_capTd              = capTd;
    next_capNext            = capNext;
    next_capRest            = capRest;
    next_capEd              = capEd;
    next_capCarry           = capCarry;
    next_capLast            = capLast;
    unique case (state)
      ST_IDLE: begin
        if (framePending) begin
          next_framePending       = frameTick;
          next_internalFrameCount = internalFrameCount + 16'h0001;
          next_sofReq             = 1'b1;
          next_state              = ST_SOF;
        end else if (resultValid && resultReady) begin
          next_capTd    = tdAddr;
          next_capNext  = tdNextPtr;
          next_capRest  = tdWord0Rest;
          next_capEd    = edAddr;
          next_capCarry = edToggleCarry;
          next_capDelay = tdIrqDelay;
          next_capLast  = tdLastPacket;
          if (isoMode) begin
            next_capHalt = 1'b0;
            next_capCode = isoSkipped ? CC_DATA_OVER : CC_OK;
            if (!isoSkipped) begin
              next_memReq   = 1'b1;
              next_memWrite = 1'b1;
              next_memAddr  = {pswAddr[31:2], 2'b00};
              next_memWdata = {pswWord, pswWord};
              next_memBe    = pswAddr[1] ? 4'hC : 4'h3;
              next_state    = ST_PSW_WR;
            end else if (tdLastPacket) begin
              next_state    = ST_ED_WR;
            end else begin
              next_edAdvance = 1'b1;
            end
          end else begin
            next_capCode       = clsCode;
            next_capHalt       = clsHalt;
            next_tdNewErrCount = clsErrCount;
            next_tdRetry       = clsRetry;
            if (clsRetire) begin
              next_state = ST_ED_WR;
            end else begin
              next_edAdvance = 1'b1;
            end
          end
          if (next_state == ST_ED_WR) begin
            next_memReq   = 1'b1;
            next_memWrite = 1'b1;
            next_memAddr  = edAddr + ED_HEAD_OFS;
            next_memBe    = 4'hF;
            next_memWdata = {tdNextPtr[31:4], 2'b00, edToggleCarry,
                             (isoMode ? 1'b0 : clsHalt)};
          end
        end
      end
      ST_SOF: begin
        if (sofDone) begin
          next_sofReq   = 1'b0;
          next_memReq   = 1'b1;
          next_memWrite = 1'b1;
          next_memAddr  = {areaBase, AREA_FRAME_OFS};
          next_memWdata = {16'h0000, internalFrameCount};
          next_memBe    = 4'hF;
          next_state    = ST_FRAME_WR;
        end
      end
      ST_FRAME_WR: begin
        if (memAck) begin
          next_memBe    = 4'hF;
          if (wbDue) begin
            next_memAddr  = {areaBase, AREA_HEAD_OFS};
            next_memWdata = {retiredQueueHead[31:1], otherIrqPending};
            next_state    = ST_HEAD_WR;
          end else begin
            next_memWrite = 1'b0;
            next_memAddr  = {areaBase, 1'b0, internalFrameCount[4:0], 2'b00};
            next_state    = ST_TABLE_RD;
          end
        end
      end
      ST_HEAD_WR: begin
        if (memAck) begin
          next_writebackStatus  = 1'b1;
          next_headPending      = 1'b0;
          next_delayCnt         = DELAY_RESET;
          next_retiredQueueHead = HEAD_RESET;
          next_memWrite         = 1'b0;
          next_memAddr          = {areaBase, 1'b0, internalFrameCount[4:0], 2'b00};
          next_state            = ST_TABLE_RD;
        end
      end
      ST_TABLE_RD: begin
        if (memAck) begin
          next_memReq       = 1'b0;
          next_periodicHead = memRdata;
          next_edFetchStart = 1'b1;
          next_state        = ST_IDLE;
        end
      end
      ST_PSW_WR: begin
        if (memAck) begin
          if (capLast) begin
            next_memAddr  = capEd + ED_HEAD_OFS;
            next_memBe    = 4'hF;
            next_memWdata = {capNext[31:4], 2'b00, capCarry, 1'b0};
            next_state    = ST_ED_WR;
          end else begin
            next_memReq    = 1'b0;
            next_edAdvance = 1'b1;
            next_state     = ST_IDLE;
          end
        end
      end
      ST_ED_WR: begin
        if (memAck) begin
          next_memAddr  = capTd + TD_NEXT_OFS;
          next_memWdata = retiredQueueHead;
          next_state    = ST_NEXT_WR;
        end
      end
      ST_NEXT_WR: begin
        if (memAck) begin
          next_memAddr  = capTd;
          next_memWdata = {capCode, capRest};
          next_state    = ST_WORD0_WR;
        end
      end
      ST_WORD0_WR: begin
        if (memAck) begin
          next_memReq           = 1'b0;
          next_retiredQueueHead = capTd;
          next_headPending      = 1'b1;
          next_delayCnt         = (headPending && decDelay < capDelay) ? decDelay : capDelay;
          next_tdRetired        = 1'b1;
          next_edHalted         = capHalt;
          next_edAdvance        = 1'b1;
          next_state            = ST_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state              <= ST_IDLE;
      framePending       <= 1'b0;
      delayCnt           <= DELAY_RESET;
      headPending        <= 1'b0;
      writebackStatus    <= 1'b0;
      retiredQueueHead   <= HEAD_RESET;
      internalFrameCount <= FRAME_RESET;
      periodicHead       <= 32'h0000_0000;
      sofReq             <= 1'b0;
      edFetchStart       <= 1'b0;
      edAdvance          <= 1'b0;
      tdRetry            <= 1'b0;
      edHalted           <= 1'b0;
      tdRetired          <= 1'b0;
      tdNewErrCount      <= 2'h0;
      memReq             <= 1'b0;
      memWrite           <= 1'b0;
      memAddr            <= 32'h0000_0000;
      memWdata           <= 32'h0000_0000;
      memBe              <= 4'h0;
      capCode            <= CC_UNTOUCHED;
      capHalt            <= 1'b0;
      capDelay           <= DELAY_RESET;
      capTd              <= 32'h0000_0000;
      capNext            <= 32'h0000_0000;
      capRest            <= 28'h000_0000;
      capEd              <= 32'h0000_0000;
      capCarry           <= 1'b0;
      capLast            <= 1'b0;
    end else begin
      state              <= next_state;
      framePending       <= next_framePending;
      delayCnt           <= next_delayCnt;
      headPending        <= next_headPending;
      writebackStatus    <= next_writebackStatus;
      retiredQueueHead   <= next_retiredQueueHead;
      internalFrameCount <= next_internalFrameCount;
      periodicHead       <= next_periodicHead;
      sofReq             <= next_sofReq;
      edFetchStart       <= next_edFetchStart;
      edAdvance          <= next_edAdvance;
      tdRetry            <= next_tdRetry;
      edHalted           <= next_edHalted;
      tdRetired          <= next_tdRetired;
      tdNewErrCount      <= next_tdNewErrCount;
      memReq             <= next_memReq;
      memWrite           <= next_memWrite;
      memAddr            <= next_memAddr;
      memWdata           <= next_memWdata;
      memBe              <= next_memBe;
      capCode            <= next_capCode;
      capHalt            <= next_capHalt;
      capDelay           <= next_capDelay;
      capTd              <= next_capTd;
      capNext            <= next_capNext;
      capRest            <= next_capRest;
      capEd              <= next_capEd;
      capCarry           <= next_capCarry;
      capLast            <= next_capLast;
    end
  end

endmodule

/* File: verilog/td_status_pkg.sv */
// Constants and types for the descriptor status write-back block
package td_status_pkg;

  // ---------------------------------------------------------------
  // Completion codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CC_OK           = 4'h0;
  localparam logic [3:0] CC_CRC          = 4'h1;
  localparam logic [3:0] CC_STUFF        = 4'h2;
  localparam logic [3:0] CC_TOGGLE       = 4'h3;
  localparam logic [3:0] CC_STALL        = 4'h4;
  localparam logic [3:0] CC_NO_RESPONSE  = 4'h5;
  localparam logic [3:0] CC_PID_CHECK    = 4'h6;
  localparam logic [3:0] CC_BAD_PID      = 4'h7;
  localparam logic [3:0] CC_DATA_OVER    = 4'h8;
  localparam logic [3:0] CC_DATA_UNDER   = 4'h9;
  localparam logic [3:0] CC_MEM_WR_LATE  = 4'hC;
  localparam logic [3:0] CC_MEM_RD_LATE  = 4'hD;
  localparam logic [3:0] CC_UNTOUCHED    = 4'hE;

  // ---------------------------------------------------------------
  // Shared area and descriptor offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  AREA_FRAME_OFS = 8'h80;
  localparam logic [7:0]  AREA_HEAD_OFS  = 8'h84;
  localparam logic [31:0] ED_HEAD_OFS    = 32'h0000_0008;
  localparam logic [31:0] TD_NEXT_OFS    = 32'h0000_0008;
  localparam logic [31:0] ISO_PSW_OFS    = 32'h0000_0010;

  // ---------------------------------------------------------------
  // Field positions and limits
  // ---------------------------------------------------------------
  localparam int          CC_POS         = 28;
  localparam int          PSW_CC_POS     = 12;
  localparam int          PSW_SIZE_W     = 11;
  localparam int          HALT_POS       = 0;
  localparam int          CARRY_POS      = 1;
  localparam logic [1:0]  ERR_LIMIT      = 2'h2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] FRAME_RESET    = 16'h0000;
  localparam logic [2:0]  DELAY_RESET    = 3'h7;
  localparam logic [31:0] HEAD_RESET     = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SOF,
    ST_FRAME_WR,
    ST_HEAD_WR,
    ST_TABLE_RD,
    ST_PSW_WR,
    ST_ED_WR,
    ST_NEXT_WR,
    ST_WORD0_WR
  } state_t;

endpackage

/* File: verilog/cc_classifier.sv */
// Maps one packet outcome to a completion code and an action
`timescale 1ns/1ps
module cc_classifier (
  // Outcome flags
  input  wire logic       crcErr,
  input  wire logic       stuffErr,
  input  wire logic       noResp,
  input  wire logic       toggleErr,
  input  wire logic       stallPid,
  input  wire logic       pidCheckErr,
  input  wire logic       badPid,
  input  wire logic       overrun,
  input  wire logic       underrun,
  input  wire logic       memWriteLate,
  input  wire logic       memReadLate,
  input  wire logic       isoMode,
  input  wire logic       tdLastPacket,
  input  wire logic [1:0] errCount,
  // Verdict
  output logic      [3:0] code,
  output logic            retire,
  output logic            retry,
  output logic            halt,
  output logic      [1:0] nextErrCount
);
  import td_status_pkg::*;

  logic transErr;
  logic anyErr;

  always_comb begin
    code = CC_OK;
    if (stallPid)
      code = CC_STALL;
    else if (overrun)
      code = CC_DATA_OVER;
    else if (underrun)
      code = CC_DATA_UNDER;
    else if (crcErr)
      code = CC_CRC;
    else if (stuffErr)
      code = CC_STUFF;
    else if (noResp)
      code = CC_NO_RESPONSE;
    else if (toggleErr)
      code = CC_TOGGLE;
    else if (pidCheckErr)
      code = CC_PID_CHECK;
    else if (badPid)
      code = CC_BAD_PID;
    else if (isoMode && memWriteLate)
      code = CC_MEM_WR_LATE;
    else if (isoMode && memReadLate)
      code = CC_MEM_RD_LATE;
    // Codes 1010 and 1011 are never produced
    transErr = (code == CC_CRC) || (code == CC_STUFF) || (code == CC_NO_RESPONSE);
    anyErr   = (code != CC_OK);
    retry    = transErr && (errCount < ERR_LIMIT);
    retire   = anyErr ? !retry : tdLastPacket;
    halt     = anyErr && retire;
    if (!anyErr)
      nextErrCount = 2'h0;
    else if (retry)
      nextErrCount = errCount + 2'h1;
    else
      nextErrCount = errCount;
  end

endmodule

/* File: verification/usb_host_td_status_writeback_props.sv */
// Checker for the descriptor status write-back block
`timescale 1ns/1ps
module usb_host_td_status_writeback_props (
  // Watched ports
  input wire logic        sys_clk, rst, sofReq, otherIrqPending, writebackStatus, resultValid, resultReady,
  input wire logic        crcErr, stallPid, overrun, underrun, isoMode, tdLastPacket, tdRetry, edHalted,
  input wire logic        tdRetired, memReq, memWrite,
  input wire logic [15:0] internalFrameCount,
  input wire logic [23:0] areaBase,
  input wire logic [1:0]  tdErrCount, tdNewErrCount,
  input wire logic [31:0] tdAddr, memAddr, memWdata,
  input wire logic [3:0]  memBe
);
  logic tk, wr;
  assign tk = resultValid && resultReady;
  assign wr = memReq && memWrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_cnt; $rose(sofReq) |-> internalFrameCount == $past(internalFrameCount) + 16'h0001; endproperty
  a_cnt: assert property (p_cnt) else $error("count late");
  property p_frm;
    wr && memAddr == {areaBase, 8'h80} |-> memWdata == {16'h0000, internalFrameCount} && memBe == 4'hF;
  endproperty
  a_frm: assert property (p_frm) else $error("frame word");
  property p_lsb; wr && memAddr == {areaBase, 8'h84} |-> memWdata[0] == otherIrqPending; endproperty
  a_lsb: assert property (p_lsb) else $error("head lsb");
  property p_once; writebackStatus |-> !(wr && memAddr == {areaBase, 8'h84}); endproperty
  a_once: assert property (p_once) else $error("head rewritten");
  property p_rty;
    tk && !isoMode && crcErr && !(stallPid || overrun || underrun) && tdErrCount < 2'h2
      |=> tdRetry && !tdRetired && tdNewErrCount == $past(tdErrCount) + 2'h1;
  endproperty
  a_rty: assert property (p_rty) else $error("no retry");
  property p_seq; tk && !isoMode && (stallPid || overrun || underrun) |=> !tdRetry ##[1:60] (tdRetired && edHalted);
  endproperty
  a_seq: assert property (p_seq) else $error("no retire");
  property p_iso; tk && isoMode && tdLastPacket |=> ##[1:60] (tdRetired && !edHalted); endproperty
  a_iso: assert property (p_iso) else $error("iso retire");
  property p_rsv; wr && memAddr == tdAddr |-> memWdata[31:29] != 3'h5; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code");
endmodule

bind usb_host_td_status_writeback usb_host_td_status_writeback_props i_props (.sys_clk, .rst, .sofReq,
  .otherIrqPending, .writebackStatus, .resultValid, .resultReady, .crcErr, .stallPid, .overrun, .underrun,
  .isoMode, .tdLastPacket, .tdRetry, .edHalted, .tdRetired, .memReq, .memWrite, .internalFrameCount,
  .areaBase, .tdErrCount, .tdNewErrCount, .tdAddr, .memAddr, .memWdata, .memBe);

/* File: verification/host_mem_model.sv */
// Behavioural system memory answering the block's memory port
`timescale 1ns/1ps
module host_mem_model (
  // Clock, reset and pacing
  input  wire logic        sys_clk, rst, slow,
  // Memory port
  input  wire logic        memReq, memWrite,
  input  wire logic [31:0] memAddr, memWdata,
  input  wire logic [3:0]  memBe,
  output logic             memAck,
  output logic      [31:0] memRdata
);
  logic [31:0] m [logic [31:0]];
  int          w;
  // Stale read data keeps toggling so nothing reads as a match
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      memAck <= 1'h0;
      memRdata <= 32'h0000_0000;
      w = 0;
    end else if (memReq && !memAck && w >= (slow ? 3 : 0)) begin
      memAck <= 1'h1;
      memRdata <= memWrite ? ~memRdata : m[memAddr];
      w = 0;
      for (int b = 0; b < 4; b++)
        if (memWrite && memBe[b])
          m[memAddr][8*b +: 8] = memWdata[8*b +: 8];
    end else begin
      memAck <= 1'h0;
      memRdata <= ~memRdata;
      w = memReq ? w + 1 : 0;
    end
  end
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the descriptor status write-back block
`timescale 1ns/1ps
module tb;
  import td_status_pkg::*;
  logic sys_clk = 0, rst = 1, frameTick = 0, sofDone = 0, writebackEnable = 0, writebackClear = 0, slow = 0;
  logic otherIrqPending = 1, resultValid = 0, crcErr = 0, stuffErr = 0, noResp = 0, toggleErr = 0, stallPid = 0;
  logic pidCheckErr = 0, badPid = 0, overrun = 0, underrun = 0, memWriteLate = 0, memReadLate = 0, isoMode = 0;
  logic isoIn = 0, isoSkipped = 0, tdLastPacket = 0, edToggleCarry = 1, rt, rd, hl;
  logic [2:0]  pktIndex = 0, tdIrqDelay = 0;
  logic [10:0] rxSize = 11'h123;
  logic [1:0]  tdErrCount = 0, tdNewErrCount;
  logic [23:0] areaBase = 24'h00_0100;
  logic [27:0] tdWord0Rest = 28'h123_4567;
  logic [31:0] tdAddr = 32'h0000_1000, tdNextPtr = 32'h0000_4440, edAddr = 32'h0000_0800;
  logic sofReq, edFetchStart, writebackStatus, resultReady, edAdvance, tdRetry, edHalted, tdRetired;
  logic memReq, memWrite, memAck;
  logic [15:0] internalFrameCount;
  logic [31:0] periodicHead, retiredQueueHead, memAddr, memWdata, memRdata;
  logic [3:0]  memBe;
  int          error_cnt = 0, n_checks = 0, fc = 0;
  always #10 sys_clk = ~sys_clk;
  usb_host_td_status_writeback i_usb_host_td_status_writeback (.sys_clk, .rst, .frameTick, .sofReq, .sofDone,
    .internalFrameCount, .periodicHead, .edFetchStart, .areaBase, .writebackEnable, .writebackClear,
    .otherIrqPending, .writebackStatus, .retiredQueueHead, .resultValid, .resultReady, .crcErr, .stuffErr,
    .noResp, .toggleErr, .stallPid, .pidCheckErr, .badPid, .overrun, .underrun, .memWriteLate, .memReadLate,
    .isoMode, .isoIn, .isoSkipped, .pktIndex, .rxSize, .tdLastPacket, .tdErrCount, .tdIrqDelay, .tdAddr,
    .tdNextPtr, .tdWord0Rest, .edAddr, .edToggleCarry, .edAdvance, .tdRetry, .tdNewErrCount, .edHalted,
    .tdRetired, .memReq, .memWrite, .memAddr, .memWdata, .memBe, .memAck, .memRdata);
  host_mem_model i_mem (.sys_clk, .rst, .slow, .memReq, .memWrite, .memAddr, .memWdata, .memBe, .memAck,
    .memRdata);
  function automatic logic [31:0] rm(input logic [31:0] a); return i_mem.m[a]; endfunction
  function automatic void wm(input logic [31:0] a, v); i_mem.m[a] = v; endfunction
  task automatic final_report();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bounded wait: 0 sof request, 1 fetch start, 2 advance, 3 outcome taken
  task automatic wt(input int s);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((s == 0 ? sofReq : s == 1 ? edFetchStart : s == 2 ? edAdvance : resultReady) !== 1'h1 && n < 200);
    if (n >= 200) begin
      $display("Error at %0t: wait timed out", $time);
      error_cnt++;
      final_report();
    end
  endtask
  task automatic frame();
    @(posedge sys_clk);
    frameTick <= 1;
    @(posedge sys_clk);
    frameTick <= 0;
    fc++;
    wt(0);
    repeat (3) @(posedge sys_clk);
    sofDone <= 1;
    @(posedge sys_clk);
    sofDone <= 0;
    wt(1);
    chk(internalFrameCount, fc);
    chk(rm({areaBase, AREA_FRAME_OFS}), {16'h0000, fc[15:0]});
    chk(periodicHead, {20'h0_0009, 3'h0, fc[4:0], 4'h0});
  endtask
  task automatic send(input logic [10:0] f, input logic iso, last);
    @(posedge sys_clk);
    {memReadLate, memWriteLate, underrun, overrun, badPid, pidCheckErr, stallPid, toggleErr, noResp, stuffErr,
      crcErr} <= f;
    isoMode <= iso;
    tdLastPacket <= last;
    resultValid <= 1;
    wt(3);
    resultValid <= 0;
    wt(2);
    rt = tdRetry;
    rd = tdRetired;
    hl = edHalted;
  endtask
  task automatic sc_codes();
    logic [3:0] cc [9] = '{4'h1, 4'h2, 4'h5, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
    for (int i = 0; i < 9; i++) begin
      wm(tdAddr, 32'hE000_0000);
      send(11'h001 << i, 0, 0);
      chk(rt, i < 3);
      chk(hl, i > 2);
      chk(rm(tdAddr), i < 3 ? 32'hE000_0000 : {cc[i], tdWord0Rest});
      if (i > 2) chk(rm(edAddr + ED_HEAD_OFS), 32'h0000_4443);
    end
    chk(retiredQueueHead, tdAddr);
    @(posedge sys_clk);
    tdErrCount <= 2'h2;
    send(11'h001, 0, 0);
    chk(rm(tdAddr), {4'h1, tdWord0Rest});
    tdErrCount <= 2'h0;
    send(11'h000, 0, 0);
    chk({rt, rd}, 0);
    send(11'h000, 0, 1);
    chk(rm(tdAddr), {4'h0, tdWord0Rest});
    chk(hl, 0);
  endtask
  task automatic sc_iso();
    wm(tdAddr, 32'hE000_0000);
    wm(tdAddr + ISO_PSW_OFS, 32'hE000_E000);
    wm(tdAddr + ISO_PSW_OFS + 4, 32'hE000_E000);
    pktIndex <= 3'h1;
    isoIn <= 1;
    send(11'h200, 1, 0);
    chk(rm(tdAddr + ISO_PSW_OFS), 32'hC123_E000);
    pktIndex <= 3'h2;
    isoIn <= 0;
    send(11'h400, 1, 0);
    chk(rm(tdAddr + ISO_PSW_OFS + 4), 32'hE000_D000);
    chk(rm(tdAddr), 32'hE000_0000);
    pktIndex <= 3'h3;
    isoSkipped <= 1;
    send(11'h000, 1, 1);
    chk(rm(tdAddr + ISO_PSW_OFS + 4), 32'hE000_D000);
    chk(rm(tdAddr), {4'h8, tdWord0Rest});
    chk({rd, hl}, 2);
    isoSkipped <= 0;
  endtask
  task automatic sc_wb();
    writebackEnable <= 1;
    tdAddr <= 32'h0000_2000;
    send(11'h000, 0, 1);
    frame();
    chk(rm({areaBase, AREA_HEAD_OFS}), 32'h0000_2001);
    chk(writebackStatus, 1);
    tdAddr <= 32'h0000_3000;
    send(11'h000, 0, 1);
    frame();
    chk(rm({areaBase, AREA_HEAD_OFS}), 32'h0000_2001);
    writebackClear <= 1;
    @(posedge sys_clk);
    writebackClear <= 0;
    frame();
    chk(rm({areaBase, AREA_HEAD_OFS}), 32'h0000_3001);
  endtask
  initial begin
    for (int i = 0; i < 32; i++) wm({areaBase, 1'h0, i[4:0], 2'h0}, {20'h0_0009, 3'h0, i[4:0], 4'h0});
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    frame();
    slow <= 1;
    frame();
    sc_codes();
    slow <= 0;
    sc_iso();
    sc_wb();
    final_report();
  end
endmodule
